// ===== rtl/rckr_pkg.sv
package rckr_pkg;

    // Printed offsets are register indices; the byte address is four times the index.
    localparam logic [15:0] RCKR_IDX_RESET_CTRL  = 16'h4006;
    localparam logic [15:0] RCKR_IDX_HOST_IF     = 16'h4007;
    localparam logic [15:0] RCKR_IDX_UNLOCK_KEY  = 16'h4008;
    localparam logic [15:0] RCKR_IDX_SCRATCH     = 16'h4009;
    localparam logic [17:0] RCKR_ADDR_RESET_CTRL = {RCKR_IDX_RESET_CTRL, 2'h0};
    localparam logic [17:0] RCKR_ADDR_HOST_IF    = {RCKR_IDX_HOST_IF, 2'h0};
    localparam logic [17:0] RCKR_ADDR_UNLOCK_KEY = {RCKR_IDX_UNLOCK_KEY, 2'h0};
    localparam logic [17:0] RCKR_ADDR_SCRATCH    = {RCKR_IDX_SCRATCH, 2'h0};
    localparam int          RCKR_ADDR_W          = 18;

    localparam int RCKR_BIT_RELOAD     = 15;
    localparam int RCKR_BIT_SCOPE      = 10;
    localparam int RCKR_BIT_AUX_LEVEL  = 6;
    localparam int RCKR_BIT_IN_MASK    = 5;
    localparam int RCKR_BIT_OUT_LEVEL  = 4;
    localparam int RCKR_BIT_DELAY_HI   = 1;
    localparam int RCKR_BIT_DELAY_LO   = 0;
    localparam int RCKR_BIT_AUTO_ADV   = 2;

    localparam logic [15:0] RCKR_UNLOCK_VALUE = 16'h9716;
    localparam logic [15:0] RCKR_KEY_RESET    = 16'h0000;
    localparam logic [15:0] RCKR_SCRATCH_RESET = 16'h0000;
    localparam logic        RCKR_RELOAD_RESET    = 1'b1;
    localparam logic        RCKR_SCOPE_RESET     = 1'b1;
    localparam logic        RCKR_AUX_LEVEL_RESET = 1'b1;
    localparam logic        RCKR_IN_MASK_RESET   = 1'b1;
    localparam logic        RCKR_OUT_LEVEL_RESET = 1'b1;
    localparam logic [1:0]  RCKR_DELAY_RESET     = 2'h3;
    localparam logic        RCKR_AUTO_ADV_RESET  = 1'b1;

    localparam int RCKR_CLK_HZ   = 10_000_000;
    localparam int RCKR_DELAY0_MS = 3;
    localparam int RCKR_DELAY1_MS = 11;
    localparam int RCKR_DELAY2_MS = 51;
    localparam int RCKR_DELAY3_MS = 101;
    localparam int RCKR_CNT_W     = 20;

    localparam logic [1:0] RCKR_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] RCKR_HSIZE_WORD    = 3'h2;

    typedef enum logic [1:0] {
        RCKR_ST_OFF,
        RCKR_ST_HOLD,
        RCKR_ST_RUN
    } rckr_rel_t;

endpackage : rckr_pkg

// ===== rtl/rckr_regs.sv
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module rckr_regs
    import rckr_pkg::*;
#(
    parameter int DELAY0_CYC = (RCKR_CLK_HZ / 1000) * RCKR_DELAY0_MS,
    parameter int DELAY1_CYC = (RCKR_CLK_HZ / 1000) * RCKR_DELAY1_MS,
    parameter int DELAY2_CYC = (RCKR_CLK_HZ / 1000) * RCKR_DELAY2_MS,
    parameter int DELAY3_CYC = (RCKR_CLK_HZ / 1000) * RCKR_DELAY3_MS
)(
    input  wire logic        clk_sys,           // System clock, 10 MHz.
    input  wire logic        reset_n,           // Asynchronous reset, active low.
    input  wire logic        backup_reset_n,    // Always-on domain reset, active low.
    input  wire logic        hsel,              // AHB-Lite slave select.
    input  wire logic [31:0] haddr,             // AHB-Lite address.
    input  wire logic [1:0]  htrans,            // AHB-Lite transfer type.
    input  wire logic        hwrite,            // AHB-Lite write flag.
    input  wire logic [2:0]  hsize,             // AHB-Lite transfer size.
    input  wire logic [31:0] hwdata,            // AHB-Lite write data.
    input  wire logic        hready,            // AHB-Lite bus ready.
    output logic      [31:0] hrdata,            // AHB-Lite read data.
    output logic             hreadyout,         // AHB-Lite slave ready.
    output logic             hresp,             // AHB-Lite response, always OKAY.
    input  wire logic        sw_reset,          // Software reset request, one-cycle pulse.
    input  wire logic        in_sleep,          // Power state is SLEEP.
    input  wire logic        on_scheduled,      // ON transition scheduled, pulse.
    input  wire logic        seq_done,          // ON or WAKE sequence done, pulse.
    input  wire logic        ext_reset_in_n,    // External reset pin, active low.
    output logic             reload_boot_req,   // Reload bootstrap data, pulse.
    output logic             ext_reset_event,   // Honoured external reset, level.
    output logic             reset_out_n,       // Reset output pin, active low.
    output logic             aux_reset_out,     // Auxiliary reset GPIO, active high.
    output logic             address_auto_advance // Host interface auto-advance.
);

    typedef struct packed {
        logic        reload_boot_config_on_power_up;
        logic        soft_reset_scope;
        logic        aux_reset_sleep_level;
        logic        sleep_reset_input_mask;
        logic        sleep_reset_output_level;
        logic [1:0]  reset_release_delay;
        logic        auto_adv;
        logic [15:0] key;
        logic        ph_write;
        logic [RCKR_ADDR_W-1:0] ph_addr;
        logic [31:0] rdata;
        logic        reload_pulse;
        logic        ext_event;
        logic        rst_out_n;
        logic        aux_out;
        rckr_rel_t   rel;
        logic [RCKR_CNT_W-1:0] cnt;
    } rckr_state_t;

    rckr_state_t st;
    rckr_state_t next_st;
    logic [15:0] host_scratch_word;
    logic [15:0] next_scratch;

    logic        addr_phase;
    logic        unlocked;
    logic [15:0] wd;
    logic [RCKR_CNT_W-1:0] delay_cyc;

    assign addr_phase = hsel && hready && (htrans == RCKR_HTRANS_NONSEQ);
    assign unlocked   = (st.key == RCKR_UNLOCK_VALUE);
    assign wd         = hwdata[15:0];

    always_comb
    begin
        case (st.reset_release_delay)
            2'h0:    delay_cyc = RCKR_CNT_W'(DELAY0_CYC);
            2'h1:    delay_cyc = RCKR_CNT_W'(DELAY1_CYC);
            2'h2:    delay_cyc = RCKR_CNT_W'(DELAY2_CYC);
            default: delay_cyc = RCKR_CNT_W'(DELAY3_CYC);
        endcase
    end

    always_comb
    begin
        next_st = st;
        next_scratch = host_scratch_word;
        next_st.reload_pulse = 1'b0;
        // Write data phase follows the captured address phase.
        if (st.ph_write)
        begin
            case (st.ph_addr)
                RCKR_ADDR_RESET_CTRL:
                begin
                    if (unlocked)
                    begin
                        next_st.reload_boot_config_on_power_up = wd[RCKR_BIT_RELOAD];
                        next_st.soft_reset_scope         = wd[RCKR_BIT_SCOPE];
                        next_st.aux_reset_sleep_level    = wd[RCKR_BIT_AUX_LEVEL];
                        next_st.sleep_reset_input_mask   = wd[RCKR_BIT_IN_MASK];
                        next_st.sleep_reset_output_level = wd[RCKR_BIT_OUT_LEVEL];
                        next_st.reset_release_delay =
                            wd[RCKR_BIT_DELAY_HI:RCKR_BIT_DELAY_LO];
                    end
                end
                RCKR_ADDR_HOST_IF:    next_st.auto_adv = wd[RCKR_BIT_AUTO_ADV];
                RCKR_ADDR_UNLOCK_KEY: next_st.key = wd;
                RCKR_ADDR_SCRATCH:    next_scratch = wd;
                default:              next_st.key = st.key;
            endcase
        end
        next_st.ph_write = addr_phase && hwrite;
        if (addr_phase)
        begin
            next_st.ph_addr = haddr[RCKR_ADDR_W-1:0];
            next_st.rdata = 32'h0000_0000;
            case (haddr[RCKR_ADDR_W-1:0])
                RCKR_ADDR_RESET_CTRL:
                begin
                    next_st.rdata[RCKR_BIT_RELOAD]    = st.reload_boot_config_on_power_up;
                    next_st.rdata[RCKR_BIT_SCOPE]     = st.soft_reset_scope;
                    next_st.rdata[RCKR_BIT_AUX_LEVEL] = st.aux_reset_sleep_level;
                    next_st.rdata[RCKR_BIT_IN_MASK]   = st.sleep_reset_input_mask;
                    next_st.rdata[RCKR_BIT_OUT_LEVEL] = st.sleep_reset_output_level;
                    next_st.rdata[RCKR_BIT_DELAY_HI:RCKR_BIT_DELAY_LO] =
                        st.reset_release_delay;
                end
                RCKR_ADDR_HOST_IF:    next_st.rdata[RCKR_BIT_AUTO_ADV] = st.auto_adv;
                RCKR_ADDR_UNLOCK_KEY: next_st.rdata[15:0] = st.key;
                RCKR_ADDR_SCRATCH:    next_st.rdata[15:0] = host_scratch_word;
                default:              next_st.rdata = 32'h0000_0000;
            endcase
        end

        // The reload request is raised only when the option is on.
        if (on_scheduled && st.reload_boot_config_on_power_up)
            next_st.reload_pulse = 1'b1;

        // A masked reset input has no effect while sleeping.
        next_st.ext_event = !ext_reset_in_n && !(in_sleep && st.sleep_reset_input_mask);

        case (st.rel)
            RCKR_ST_OFF:
            begin
                if (seq_done)
                begin
                    next_st.rel = RCKR_ST_HOLD;
                    next_st.cnt = delay_cyc;
                end
            end
            RCKR_ST_HOLD:
            begin
                if (st.cnt <= RCKR_CNT_W'(1))
                    next_st.rel = RCKR_ST_RUN;
                else
                    next_st.cnt = st.cnt - RCKR_CNT_W'(1);
            end
            RCKR_ST_RUN:
            begin
                if (seq_done)
                begin
                    next_st.rel = RCKR_ST_HOLD;
                    next_st.cnt = delay_cyc;
                end
            end
            default: next_st.rel = RCKR_ST_OFF;
        endcase

        if (in_sleep)
        begin
            next_st.rst_out_n = !st.sleep_reset_output_level;
            next_st.aux_out   = st.aux_reset_sleep_level;
        end
        else
        begin
            // Follow the next release state so a new sequence re-asserts at once.
            next_st.rst_out_n = (next_st.rel == RCKR_ST_RUN);
            next_st.aux_out   = (next_st.rel != RCKR_ST_RUN);
        end

        // With scope 0 a soft reset restores defaults; the always-on scratch is kept.
        if (sw_reset && !st.soft_reset_scope)
        begin
            next_st.reload_boot_config_on_power_up = RCKR_RELOAD_RESET;
            next_st.soft_reset_scope         = RCKR_SCOPE_RESET;
            next_st.aux_reset_sleep_level    = RCKR_AUX_LEVEL_RESET;
            next_st.sleep_reset_input_mask   = RCKR_IN_MASK_RESET;
            next_st.sleep_reset_output_level = RCKR_OUT_LEVEL_RESET;
            next_st.reset_release_delay      = RCKR_DELAY_RESET;
            next_st.auto_adv                 = RCKR_AUTO_ADV_RESET;
            next_st.key                      = RCKR_KEY_RESET;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st <= '{
                reload_boot_config_on_power_up: RCKR_RELOAD_RESET,
                soft_reset_scope:         RCKR_SCOPE_RESET,
                aux_reset_sleep_level:    RCKR_AUX_LEVEL_RESET,
                sleep_reset_input_mask:   RCKR_IN_MASK_RESET,
                sleep_reset_output_level: RCKR_OUT_LEVEL_RESET,
                reset_release_delay:      RCKR_DELAY_RESET,
                auto_adv:                 RCKR_AUTO_ADV_RESET,
                key:                      RCKR_KEY_RESET,
                rel:                      RCKR_ST_OFF,
                default:                  '0
            };
        end
        else
        begin
            st <= next_st;
        end
    end

    // Scratch lives on the always-on reset so BACKUP does not clear it.
    always_ff @(posedge clk_sys or negedge backup_reset_n)
    begin
        if (!backup_reset_n)
            host_scratch_word <= RCKR_SCRATCH_RESET;
        else
            host_scratch_word <= next_scratch;
    end

    assign hrdata               = st.rdata;
    assign hreadyout            = 1'b1;
    assign hresp                = 1'b0;
    assign reload_boot_req      = st.reload_pulse;
    assign ext_reset_event      = st.ext_event;
    assign reset_out_n          = st.rst_out_n;
    assign aux_reset_out        = st.aux_out;
    assign address_auto_advance = st.auto_adv;

endmodule : rckr_regs

`default_nettype wire

// ===== tb/rckr_host.sv
`timescale 1ns/1ps
`default_nettype none
module rckr_host
    import rckr_pkg::*;
(
    input  wire logic        clk_sys, // Bus clock.
    input  wire logic        hready,  // Bus ready.
    input  wire logic [31:0] hrdata,  // Read data.
    output logic      [31:0] haddr,   // Address.
    output logic      [1:0]  htrans,  // Transfer type.
    output logic             hwrite,  // Write flag.
    output logic      [2:0]  hsize,   // Transfer size.
    output logic      [31:0] hwdata   // Write data.
);
    assign hsize = RCKR_HSIZE_WORD;
    initial
    begin
        {haddr, htrans, hwrite, hwdata} = '0;
    end
    // The count of waits is bounded so a dead slave ends the run.
    task automatic wait_rdy();
        int n;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk_sys);
            if (hready === 1'b1)
                return;
        end
        testbench.failures++;
        testbench.report_and_stop();
    endtask : wait_rdy
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        haddr  <= a;
        htrans <= RCKR_HTRANS_NONSEQ;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask : xfer
    task automatic unlock();
        logic [31:0] q;
        xfer(1'b1, 32'(RCKR_ADDR_UNLOCK_KEY), 32'(RCKR_UNLOCK_VALUE), q);
    endtask : unlock
endmodule : rckr_host
`default_nettype wire

// ===== tb/rckr_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rckr_regs_chk (
    input wire logic        clk_sys,         // Clock.
    input wire logic        reset_n,         // Reset, active low.
    input wire logic [31:0] hrdata,          // Read data.
    input wire logic        hreadyout,       // Slave ready.
    input wire logic        hresp,           // Response.
    input wire logic        on_scheduled,    // ON scheduled.
    input wire logic        seq_done,        // Sequence done.
    input wire logic        in_sleep,        // SLEEP state.
    input wire logic        ext_reset_in_n,  // External reset pin.
    input wire logic        reload_boot_req, // Reload request.
    input wire logic        ext_reset_event, // Honoured reset.
    input wire logic        reset_out_n      // Reset output.
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    reload_src_a: assert property (reload_boot_req |-> $past(on_scheduled))
        else $error("reload pulse without ON request");
    reload_one_a: assert property (reload_boot_req |=> !reload_boot_req)
        else $error("reload pulse longer than one cycle");
    ext_src_a: assert property (ext_reset_event |-> !$past(ext_reset_in_n))
        else $error("reset event without low pin");
    ext_pass_a: assert property (!in_sleep && !ext_reset_in_n |=> ext_reset_event)
        else $error("awake reset pin not honoured");
    resp_ok_a: assert property (hresp == 1'b0)
        else $error("response not OKAY");
    ready_hi_a: assert property (hreadyout)
        else $error("slave inserted wait state");
    rdata_hi_a: assert property (hrdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    rel_hold_a: assert property (seq_done && !in_sleep |=> !reset_out_n [*3])
        else $error("reset released before shortest delay");
    rel_bound_a: assert property (seq_done && !in_sleep |-> ##[1:110] reset_out_n)
        else $error("reset not released after longest delay");
endmodule : rckr_regs_chk
bind rckr_regs rckr_regs_chk u_chk (.*);
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import rckr_pkg::*;
;
    localparam logic [31:0] A_CTL = 32'(RCKR_ADDR_RESET_CTRL);
    localparam logic [31:0] A_IF  = 32'(RCKR_ADDR_HOST_IF);
    localparam logic [31:0] A_KEY = 32'(RCKR_ADDR_UNLOCK_KEY);
    localparam logic [31:0] A_SCR = 32'(RCKR_ADDR_SCRATCH);
    localparam logic [31:0] DEF   = 32'h8473;
    logic        clk_sys, reset_n, backup_reset_n, hsel, hwrite, hreadyout, hresp;
    logic        sw_reset, in_sleep, on_scheduled, seq_done, ext_reset_in_n;
    logic        reload_boot_req, ext_reset_event, reset_out_n, aux_reset_out;
    logic        address_auto_advance;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    wire logic   hready;
    int          failures, checks_done, n, c;
    int          dly[4] = '{3, 11, 51, 101};
    assign hready = hreadyout;
    rckr_regs #(.DELAY0_CYC(3), .DELAY1_CYC(11), .DELAY2_CYC(51), .DELAY3_CYC(101)) dut (.*);
    rckr_host host (.*);
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        host.xfer(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rd
    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
    endtask : do_reset
    task automatic t_access();
        rd(A_CTL, DEF);
        rd(A_IF, 32'h4);
        rd(A_SCR, 32'h0);
        wr(A_CTL, 32'h0);
        rd(A_CTL, DEF);
        wr(32'h10028, 32'h1234);
        rd(32'h10028, 32'h0);
        host.unlock();
        wr(A_CTL, 32'h0);
        rd(A_CTL, 32'h0);
        wr(A_IF, 32'h0);
        wr(A_SCR, 32'hA5C3);
        rd(A_SCR, 32'hA5C3);
        repeat (2) @(posedge clk_sys);
        chk(32'(address_auto_advance), 32'h0);
    endtask : t_access
    task automatic t_soft();
        sw_reset <= 1'b1;
        @(posedge clk_sys);
        sw_reset <= 1'b0;
        rd(A_CTL, DEF);
        rd(A_IF, 32'h4);
        rd(A_KEY, 32'h0);
        rd(A_SCR, 32'hA5C3);
        host.unlock();
        wr(A_CTL, 32'h0403);
        sw_reset <= 1'b1;
        @(posedge clk_sys);
        sw_reset <= 1'b0;
        rd(A_CTL, 32'h0403);
        do_reset();
        rd(A_SCR, 32'hA5C3);
        backup_reset_n <= 1'b0;
        @(posedge clk_sys);
        backup_reset_n <= 1'b1;
        rd(A_SCR, 32'h0);
    endtask : t_soft
    task automatic t_reload();
        for (c = 0; c < 2; c++)
        begin
            on_scheduled <= 1'b1;
            @(posedge clk_sys);
            on_scheduled <= 1'b0;
            @(posedge clk_sys);
            chk(32'(reload_boot_req), 32'(c == 0));
            host.unlock();
            wr(A_CTL, 32'h0473);
        end
    endtask : t_reload
    // Pin is held low throughout so the mask bit alone decides the event.
    task automatic t_sleep();
        in_sleep       <= 1'b1;
        ext_reset_in_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(32'({reset_out_n, aux_reset_out, ext_reset_event}), 32'h2);
        wr(A_CTL, 32'h0403);
        repeat (3) @(posedge clk_sys);
        chk(32'({reset_out_n, aux_reset_out, ext_reset_event}), 32'h5);
        in_sleep       <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(32'(ext_reset_event), 32'h1);
        ext_reset_in_n <= 1'b1;
    endtask : t_sleep
    task automatic t_delay();
        for (c = 0; c < 4; c++)
        begin
            do_reset();
            host.unlock();
            wr(A_CTL, 32'h8470 | c);
            chk(32'(reset_out_n), 32'h0);
            seq_done <= 1'b1;
            @(posedge clk_sys);
            seq_done <= 1'b0;
            for (n = 0; n < 200 && reset_out_n !== 1'b1; n++)
                @(posedge clk_sys);
            if (n == 200)
            begin
                failures++;
                report_and_stop();
            end
            chk(32'(n >= dly[c] && n <= dly[c] + 3), 32'h1);
        end
    endtask : t_delay
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    initial
    begin
        {reset_n, hsel, sw_reset, in_sleep, on_scheduled, seq_done} = 6'h10;
        {backup_reset_n, ext_reset_in_n} = 2'h3;
        backup_reset_n = 1'b0;
        @(posedge clk_sys);
        backup_reset_n <= 1'b1;
        do_reset();
        t_access();
        t_soft();
        host.unlock();
        t_reload();
        t_sleep();
        t_delay();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
